// File: design/cpds_oneshot.sv
`timescale 1ns/10ps
`default_nettype none
module cpds_oneshot #(
	parameter int unsigned WINDOW_CYCLES = cpds_pkg::BLANK_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	input  wire logic enable_in,
	input  wire logic trigger_in,
	output logic      open_out
);

	localparam int unsigned CW = $clog2(WINDOW_CYCLES + 1);

	typedef struct packed {
		cpds_pkg::cpds_os_e st;
		logic [CW-1:0]      cnt;
	} cpds_os_s;

	cpds_os_s s_r;
	cpds_os_s s_nxt;

	// ==========================================================
	// Blanking window timer.
	// ==========================================================
	// A trigger while the window is open is ignored, as in a monostable.
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			cpds_pkg::CPDS_OS_IDLE: begin
				if (enable_in && trigger_in) begin
					s_nxt.st  = cpds_pkg::CPDS_OS_OPEN;
					s_nxt.cnt = CW'(WINDOW_CYCLES - 1);
				end
			end
			cpds_pkg::CPDS_OS_OPEN: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = cpds_pkg::CPDS_OS_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			default: begin
				s_nxt.st  = cpds_pkg::CPDS_OS_IDLE;
				s_nxt.cnt = '0;
			end
		endcase
		// Without the standard-select level the one-shot has no supply.
		if (!enable_in) begin
			s_nxt.st  = cpds_pkg::CPDS_OS_IDLE;
			s_nxt.cnt = '0;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r.st  <= cpds_pkg::CPDS_OS_IDLE;
			s_r.cnt <= '0;
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	assign open_out = (s_r.st == cpds_pkg::CPDS_OS_OPEN);

endmodule // cpds_oneshot
`default_nettype wire

// File: design/cpds_pair_buf.sv
`timescale 1ns/10ps
`default_nettype none
module cpds_pair_buf #(
	parameter int unsigned WIDTH = cpds_pkg::SEQ_W,
	parameter int unsigned DEPTH = cpds_pkg::BUF_DEPTH
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             ce_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned NW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [NW-1:0]               fill;
	} cpds_buf_s;

	cpds_buf_s s_r;
	cpds_buf_s s_nxt;
	logic      push;
	logic      pop;

	// ==========================================================
	// Handshakes.
	// ==========================================================
	// Full and empty come straight from the fill count.
	assign in_ready_out  = (s_r.fill != NW'(DEPTH));
	assign out_valid_out = (s_r.fill != '0);
	assign out_data_out  = s_r.mem[s_r.rptr];
	assign push          = in_valid_in && in_ready_out && ce_in;
	assign pop           = out_valid_out && out_ready_in && ce_in;

	// Pointer and storage update; pointers wrap at the depth.
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wptr] = in_data_in;
			s_nxt.wptr = (s_r.wptr == PW'(DEPTH - 1)) ? '0 : s_r.wptr + 1'b1;
		end
		if (pop) begin
			s_nxt.rptr = (s_r.rptr == PW'(DEPTH - 1)) ? '0 : s_r.rptr + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.fill = s_r.fill + 1'b1;
		end else if (pop && !push) begin
			s_nxt.fill = s_r.fill - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

endmodule // cpds_pair_buf
`default_nettype wire

// File: design/cpds_top.sv
`timescale 1ns/10ps
`default_nettype none
module cpds_top #(
	parameter int unsigned BLANK_CYCLES = cpds_pkg::BLANK_CYCLES,
	parameter int unsigned SEQ_W        = cpds_pkg::SEQ_W,
	parameter int unsigned BUF_DEPTH    = cpds_pkg::BUF_DEPTH
) (
	input  wire logic             CLK_IN,
	input  wire logic             RST_N_IN,
	input  wire logic             CE_IN,
	input  wire logic             CT_PULSE_IN,
	input  wire logic             STANDARD_SELECT_LEVEL_IN,
	input  wire logic             FRAME_LOCK_MODE_IN,
	input  wire logic             TAPE_FRAME_PULSE_IN,
	input  wire logic             DIV_READY_IN,
	output logic                  GATED_PULSE_OUT,
	output logic                  BLANK_WINDOW_OUT,
	output logic      [2:0]       DIV_STAGE_OUT,
	output logic                  DIV8_OUT,
	output logic                  RESET_PULSE_OUT,
	output logic                  GATE_MATRIX_PROBE_OUT,
	output logic                  DIV_VALID_OUT,
	output logic      [SEQ_W-1:0] DIV_SEQ_OUT
);

	localparam int unsigned NS = cpds_pkg::DIV_STAGES;

	// All state of the block outside the one-shot and the buffer in one record.
	typedef struct packed {
		logic [NS-1:0]         div;
		logic                  gated_d;
		logic                  gated_q;
		logic                  frame_d;
		logic                  coin_d;
		logic                  reset_q;
		cpds_pkg::cpds_gate_e  gate;
		logic [SEQ_W-1:0]      seq;
	} cpds_top_s;

	cpds_top_s   s_r;
	cpds_top_s   s_nxt;

	logic        skip_en;
	logic        blank;
	logic        gated;
	logic        gated_rise;
	logic        buf_ready;
	logic        advance;
	logic [NS:0] tog;
	logic        trigger;
	logic        wrap;
	logic        coin;
	logic        coin_rise;
	logic        frame_rise;
	logic        reset_pulse;
	logic        push;

	// ==========================================================
	// Mode select.
	// ==========================================================
	// A high standard-select level enables pulse skipping; low keeps
	// the divider running as a plain eight-way chain.
	assign skip_en = STANDARD_SELECT_LEVEL_IN;

	// ==========================================================
	// Pulse-skip gate.
	// ==========================================================
	// The gate sits between the delayed control-track pulse and the
	// first stage; while the blanking window is open the pulse is
	// clamped away. Because the window opens the cycle after the
	// counter advanced, a passed pulse that fires the one-shot is cut
	// short right after its leading edge.
	assign gated      = CT_PULSE_IN && !blank;
	assign gated_rise = gated && !s_r.gated_d;

	// The first stage advances on the leading edge of a passed pulse.
	// While the output buffer is full the edge is not taken, so no
	// divided event is ever dropped; the chain simply stalls.
	assign advance = gated_rise && buf_ready && !reset_pulse;

	// ==========================================================
	// Divider chain.
	// ==========================================================
	// Each stage toggles when the stage below it falls; tog[i] marks
	// that stage i toggles this cycle, and tog[NS] is the carry out
	// of the last stage, i.e. the end of an eight-pulse count.
	assign tog[0] = advance;
	genvar gi;
	generate
		for (gi = 1; gi <= NS; gi++) begin : g_stage
			assign tog[gi] = tog[gi-1] && s_r.div[gi-1];
		end
	endgenerate

	// The second stage falls at the start of each four-pulse half,
	// which in fifty-hertz mode fires the blanking one-shot. The
	// window then swallows the next pulse, so the second and seventh
	// pulses of every ten vanish and two intervals stretch to two
	// control-track periods.
	assign trigger = tog[cpds_pkg::TRIG_STAGE] && skip_en;

	// One divided output per eight passed pulses: ten inputs in
	// fifty-hertz mode, so 250 per second in gives 25 out.
	assign wrap = tog[NS];

	// ==========================================================
	// Blanking one-shot.
	// ==========================================================
	cpds_oneshot #(
		.WINDOW_CYCLES (BLANK_CYCLES)
	) u_oneshot (
		.clk_in     (CLK_IN),
		.rst_n_in   (RST_N_IN),
		.ce_in      (CE_IN),
		.enable_in  (skip_en),
		.trigger_in (trigger),
		.open_out   (blank)
	);

	// ==========================================================
	// Reset pulse gating.
	// ==========================================================
	// Coincidence is all stages at their final level together. Its
	// leading edge arms the frame gate; a tape frame pulse seen while
	// armed in frame-locked mode yields a one-cycle reset that puts
	// the chain back in its start state and disarms the gate.
	assign coin        = &s_r.div;
	assign coin_rise   = coin && !s_r.coin_d;
	assign frame_rise  = TAPE_FRAME_PULSE_IN && !s_r.frame_d;
	assign reset_pulse = FRAME_LOCK_MODE_IN && frame_rise &&
	                     (s_r.gate == cpds_pkg::CPDS_GT_ARMED);

	// A divided event goes into the buffer at each count wrap.
	assign push = wrap;

	// ==========================================================
	// Next-state logic.
	// ==========================================================
	// Edge trackers, the divider, the gate latch and the sequence tag.
	always_comb begin
		s_nxt         = s_r;
		s_nxt.gated_d = gated;
		s_nxt.gated_q = gated;
		s_nxt.frame_d = TAPE_FRAME_PULSE_IN;
		s_nxt.coin_d  = coin;
		s_nxt.reset_q = reset_pulse;
		s_nxt.div     = s_r.div ^ tog[NS-1:0];
		if (push) begin
			s_nxt.seq = s_r.seq + 1'b1;
		end
		case (s_r.gate)
			cpds_pkg::CPDS_GT_DISARMED: begin
				if (coin_rise) begin
					s_nxt.gate = cpds_pkg::CPDS_GT_ARMED;
				end
			end
			cpds_pkg::CPDS_GT_ARMED: begin
				// Further coincidences leave the latch as it is.
				s_nxt.gate = cpds_pkg::CPDS_GT_ARMED;
			end
			default: begin
				s_nxt.gate = cpds_pkg::CPDS_GT_DISARMED;
			end
		endcase
		// The reset overrides both the count and the coincidence it
		// creates; the coincidence edge is masked for that reason.
		if (reset_pulse) begin
			s_nxt.div    = cpds_pkg::DIV_START;
			s_nxt.gate   = cpds_pkg::CPDS_GT_DISARMED;
			s_nxt.coin_d = 1'b1;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_r.div     <= cpds_pkg::DIV_START;
			s_r.gated_d <= 1'b0;
			s_r.gated_q <= 1'b0;
			s_r.frame_d <= 1'b0;
			s_r.coin_d  <= 1'b1;
			s_r.reset_q <= 1'b0;
			s_r.gate    <= cpds_pkg::CPDS_GT_DISARMED;
			s_r.seq     <= cpds_pkg::SEQ_RESET;
		end else if (CE_IN) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Divided-event buffer.
	// ==========================================================
	// Two entries hold wrap tags so that a slow receiver loses none.
	cpds_pair_buf #(
		.WIDTH (SEQ_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_in        (CLK_IN),
		.rst_n_in      (RST_N_IN),
		.ce_in         (CE_IN),
		.in_valid_in   (push),
		.in_ready_out  (buf_ready),
		.in_data_in    (s_r.seq),
		.out_valid_out (DIV_VALID_OUT),
		.out_ready_in  (DIV_READY_IN),
		.out_data_out  (DIV_SEQ_OUT)
	);

	// ==========================================================
	// Outputs.
	// ==========================================================
	// The probe shows the armed latch and the reset pulse added.
	assign GATED_PULSE_OUT       = s_r.gated_q;
	assign BLANK_WINDOW_OUT      = blank;
	assign DIV_STAGE_OUT         = s_r.div;
	assign DIV8_OUT              = s_r.div[NS-1]; // Falls once per count.
	assign RESET_PULSE_OUT       = s_r.reset_q;
	assign GATE_MATRIX_PROBE_OUT = (s_r.gate == cpds_pkg::CPDS_GT_ARMED) || s_r.reset_q;

endmodule // cpds_top
`default_nettype wire

// File: inc/cpds_pkg.sv
// Contract
// - Fifty-hertz mode drops two of ten pulses.
// - Fifty-hertz mode divides 250 down to 25.
// - Three stages give one output per eight.
// - 525-line mode passes every pulse unaltered.
// - Standard-select level chooses mode; high skips.
// - Second stage falling edge fires blanking one-shot.
// - Window lasts about 6 ms, suppressing pulses.
// - Window expiry reopens the pulse path.
// - Second and seventh pulses of ten suppressed.
// - First and sixth passed pulses are truncated.
// - Intervals after first and sixth are doubled.
// - Delay, divider, reset gating same both modes.
// - Skip gate sits before first stage trigger.
// - Frame pulse after coincidence resets divider chain.
// - Armed gate ignores coincidences until next reset.
package cpds_pkg;

	// ==========================================================
	// Timing.
	// ==========================================================
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned BLANK_TIME_US  = 6000;
	// Blanking window in system clock cycles, rounded down.
	localparam int unsigned BLANK_CYCLES   = (BLANK_TIME_US * 1000) / CLK_PERIOD_NS;

	// ==========================================================
	// Divider chain and output stream.
	// ==========================================================
	localparam int unsigned DIV_STAGES     = 3;
	localparam int unsigned TRIG_STAGE     = 2;
	localparam logic [2:0]  DIV_START      = 3'h7;
	localparam int unsigned SEQ_W          = 8;
	localparam logic [7:0]  SEQ_RESET      = 8'h00;
	localparam int unsigned BUF_DEPTH      = 2;

	// ==========================================================
	// State encodings.
	// ==========================================================
	typedef enum logic [1:0] {
		CPDS_OS_IDLE = 2'b01,
		CPDS_OS_OPEN = 2'b10
	} cpds_os_e;

	typedef enum logic [1:0] {
		CPDS_GT_DISARMED = 2'b01,
		CPDS_GT_ARMED    = 2'b10
	} cpds_gate_e;

endpackage

// File: test/cpds_sink.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Receiver of divided events, slow at random or stalled.
module cpds_sink (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       stall_in,
	input wire logic       valid_in,
	input wire logic [7:0] data_in,
	output logic           ready_out,
	output logic     [7:0] pops_out,
	output logic     [7:0] last_out
);
	int seed = 32'h7ed9678c;
	// Takes tags when ready and keeps the count and the last tag.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ready_out <= 1'b0;
			pops_out <= 8'h00;
			last_out <= 8'h00;
		end else begin
			ready_out <= !stall_in && (($random(seed) & 1) != 0);
			if (valid_in && ready_out) begin
				pops_out <= pops_out + 8'h01;
				last_out <= data_in;
			end
		end
	end
endmodule // cpds_sink
`default_nettype wire

// File: test/cpds_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the control pulse divider.
module cpds_top_chk #(
	parameter int unsigned BLANK_CYCLES = cpds_pkg::BLANK_CYCLES
) (
	input wire logic       CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic       CE_IN,
	input wire logic       DIV_READY_IN,
	input wire logic       STANDARD_SELECT_LEVEL_IN,
	input wire logic       FRAME_LOCK_MODE_IN,
	input wire logic       TAPE_FRAME_PULSE_IN,
	input wire logic       GATED_PULSE_OUT,
	input wire logic       BLANK_WINDOW_OUT,
	input wire logic [2:0] DIV_STAGE_OUT,
	input wire logic       DIV8_OUT,
	input wire logic       RESET_PULSE_OUT,
	input wire logic       GATE_MATRIX_PROBE_OUT,
	input wire logic       DIV_VALID_OUT
);
	logic [31:0] cnt_r;
	logic [1:0]  fill_r;
	logic [2:0]  div_q_r;
	logic        pop_q_r;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Counts how long the blanking window has stood.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) cnt_r <= 32'h0;
		else cnt_r <= BLANK_WINDOW_OUT ? cnt_r + 32'h1 : 32'h0;
	end
	// Mirrors the output buffer fill from the wraps and pops seen at the ports.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fill_r  <= 2'h0;
			div_q_r <= 3'h7;
			pop_q_r <= 1'b0;
		end else begin
			fill_r  <= fill_r + 2'((div_q_r == 3'h7) && (DIV_STAGE_OUT == 3'h0)) - 2'(pop_q_r);
			div_q_r <= DIV_STAGE_OUT;
			pop_q_r <= DIV_VALID_OUT && DIV_READY_IN && CE_IN;
		end
	end
	sequence s_wrap; $past(DIV_STAGE_OUT) == 3'h7 && DIV_STAGE_OUT == 3'h0; endsequence
	sequence s_armed_frame;
		$rose(TAPE_FRAME_PULSE_IN) && FRAME_LOCK_MODE_IN && GATE_MATRIX_PROBE_OUT && !RESET_PULSE_OUT;
	endsequence
	sequence s_reset_done;
		RESET_PULSE_OUT && DIV_STAGE_OUT == 3'h7 ##1 !RESET_PULSE_OUT && !GATE_MATRIX_PROBE_OUT;
	endsequence
	property p_div8; DIV8_OUT == DIV_STAGE_OUT[2]; endproperty
	property p_step;
		$changed(DIV_STAGE_OUT) && !RESET_PULSE_OUT |-> DIV_STAGE_OUT == $past(DIV_STAGE_OUT) + 3'h1;
	endproperty
	// A passed pulse counts unless the buffer was full and the pulse was dropped.
	property p_gated; $rose(GATED_PULSE_OUT) && fill_r != 2'h2 |-> $changed(DIV_STAGE_OUT); endproperty
	property p_525; !STANDARD_SELECT_LEVEL_IN |-> !BLANK_WINDOW_OUT; endproperty
	property p_trig;
		STANDARD_SELECT_LEVEL_IN && $fell(DIV_STAGE_OUT[1]) && !$past(BLANK_WINDOW_OUT) |-> BLANK_WINDOW_OUT;
	endproperty
	property p_hide; BLANK_WINDOW_OUT |=> !$rose(GATED_PULSE_OUT); endproperty
	property p_len_max; BLANK_WINDOW_OUT |-> cnt_r < BLANK_CYCLES; endproperty
	property p_len; $fell(BLANK_WINDOW_OUT) |-> cnt_r == BLANK_CYCLES; endproperty
	property p_trunc; $rose(GATED_PULSE_OUT) && $rose(BLANK_WINDOW_OUT) |=> !GATED_PULSE_OUT; endproperty
	property p_frame; s_armed_frame |=> s_reset_done; endproperty
	property p_ignore; $rose(TAPE_FRAME_PULSE_IN) && !GATE_MATRIX_PROBE_OUT |=> !RESET_PULSE_OUT; endproperty
	property p_wrap; s_wrap |-> DIV_VALID_OUT; endproperty
	a_div8: assert property (p_div8) else $error("div8 differs from stage 2");
	a_step: assert property (p_step) else $error("divider did not step by one");
	a_gated: assert property (p_gated) else $error("gated pulse without count");
	a_525: assert property (p_525) else $error("blanking in 525 mode");
	a_trig: assert property (p_trig) else $error("window not triggered");
	a_hide: assert property (p_hide) else $error("pulse passed in window");
	a_len_max: assert property (p_len_max) else $error("window too long");
	a_len: assert property (p_len) else $error("window length wrong");
	a_trunc: assert property (p_trunc) else $error("pulse not truncated");
	a_frame: assert property (p_frame) else $error("frame reset wrong");
	a_ignore: assert property (p_ignore) else $error("reset while disarmed");
	a_wrap: assert property (p_wrap) else $error("no event on wrap");
endmodule // cpds_top_chk
bind cpds_top cpds_top_chk #(.BLANK_CYCLES(BLANK_CYCLES)) chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.CE_IN(CE_IN), .DIV_READY_IN(DIV_READY_IN),
	.STANDARD_SELECT_LEVEL_IN(STANDARD_SELECT_LEVEL_IN), .FRAME_LOCK_MODE_IN(FRAME_LOCK_MODE_IN),
	.TAPE_FRAME_PULSE_IN(TAPE_FRAME_PULSE_IN), .GATED_PULSE_OUT(GATED_PULSE_OUT),
	.BLANK_WINDOW_OUT(BLANK_WINDOW_OUT), .DIV_STAGE_OUT(DIV_STAGE_OUT), .DIV8_OUT(DIV8_OUT),
	.RESET_PULSE_OUT(RESET_PULSE_OUT), .GATE_MATRIX_PROBE_OUT(GATE_MATRIX_PROBE_OUT),
	.DIV_VALID_OUT(DIV_VALID_OUT));
`default_nettype wire

// File: test/tb_control_pulse_divider_with_skip.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the control pulse divider.
module tb_control_pulse_divider_with_skip;
	localparam int unsigned BLANK = 60;
	logic       clk, rst_n, ce, ct, ssl, flm, frm, stall, rdy, gated, blank, div8, rpulse, probe, valid, g, r;
	logic [2:0] div, d;
	logic [7:0] seq, pops, last;
	int         fails, num_checks, seed, taken;
	cpds_top #(.BLANK_CYCLES(BLANK)) dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .CT_PULSE_IN(ct),
		.STANDARD_SELECT_LEVEL_IN(ssl), .FRAME_LOCK_MODE_IN(flm), .TAPE_FRAME_PULSE_IN(frm),
		.DIV_READY_IN(rdy), .GATED_PULSE_OUT(gated), .BLANK_WINDOW_OUT(blank), .DIV_STAGE_OUT(div),
		.DIV8_OUT(div8), .RESET_PULSE_OUT(rpulse), .GATE_MATRIX_PROBE_OUT(probe), .DIV_VALID_OUT(valid),
		.DIV_SEQ_OUT(seq));
	cpds_sink sink_u (.clk_in(clk), .rst_n_in(rst_n), .stall_in(stall), .valid_in(valid), .data_in(seq),
		.ready_out(rdy), .pops_out(pops), .last_out(last));
	// Clock with a 50 ns period.
	always #25 clk = ~clk;
	// Pulses that reach the counter in skip mode, counted from zero.
	function automatic logic exp_pass(input int i);
		return (i % 10 != 1) && (i % 10 != 6);
	endfunction
	// The window still stands late in the gap after the pulses that fire it.
	function automatic logic exp_blank(input int i);
		return (i % 10 == 0) || (i % 10 == 5);
	endfunction
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] o);
		num_checks++;
		if (o !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, e, o);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset(input logic mode);
		rst_n <= 1'b0;
		ssl <= mode;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask
	// One control-track pulse, two cycles wide, then a gap.
	task automatic pulse(input int gap, output logic gp);
		@(posedge clk) ct <= 1'b1;
		@(posedge clk);
		#1 gp = gated;
		@(posedge clk) ct <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask
	task automatic frame(output logic rp, output logic [2:0] dv);
		@(posedge clk) frm <= 1'b1;
		@(posedge clk);
		#1 rp = rpulse;
		dv = div;
		@(posedge clk) frm <= 1'b0;
	endtask
	// Lets the receiver empty the buffer, with a bounded wait.
	task automatic drain();
		int i;
		stall <= 1'b0;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if (valid === 1'b0) break;
		end
		if (i == 300) begin
			fails++;
			complete_run();
		end
	endtask
	// Main sequence of tests.
	initial begin
		clk = 0; rst_n = 0; ct = 0; ssl = 0; flm = 0; frm = 0; stall = 0;
		ce = 1;
		seed = 32'h7ed9678c; fails = 0; num_checks = 0;
		do_reset(1'b0);
		chk("div", 8'h07, {5'h00, div});
		chk("div8", 8'h01, {7'h00, div8});
		chk("valid", 8'h00, {7'h00, valid});
		$display("test reset done");
		for (int i = 0; i < 20; i++) begin
			pulse(3 + $unsigned($random(seed)) % 16, g);
			chk("gated", 8'h01, {7'h00, g});
		end
		chk("div", 8'h03, {5'h00, div});
		drain();
		chk("pops", 8'h03, pops);
		chk("last", 8'h02, last);
		// A pulse while the clock enable is low must leave all state alone.
		ce <= 1'b0;
		pulse(4, g);
		ce <= 1'b1;
		chk("frozen gated", 8'h00, {7'h00, g});
		@(posedge clk);
		#1 chk("frozen div", 8'h03, {5'h00, div});
		$display("test 525 done");
		do_reset(1'b1);
		taken = 0;
		for (int i = 0; i < 20; i++) begin
			pulse(38, g);
			chk("gated", {7'h00, exp_pass(i)}, {7'h00, g});
			#1 chk("blank", {7'h00, exp_blank(i)}, {7'h00, blank});
			if (exp_pass(i)) taken++;
		end
		chk("div", 8'((7 + taken) % 8), {5'h00, div});
		drain();
		chk("pops", 8'((taken + 7) / 8), pops);
		$display("test skip done");
		do_reset(1'b0);
		flm <= 1'b1;
		repeat (8) pulse(6, g);
		chk("probe", 8'h01, {7'h00, probe});
		repeat (2) pulse(6, g);
		frame(r, d);
		chk("reset", 8'h01, {7'h00, r});
		chk("div", 8'h07, {5'h00, d});
		@(posedge clk);
		#1 chk("probe", 8'h00, {7'h00, probe});
		frame(r, d);
		chk("reset", 8'h00, {7'h00, r});
		pulse(4, g);
		chk("div", 8'h00, {5'h00, div});
		flm <= 1'b0;
		$display("test frame done");
		do_reset(1'b0);
		stall <= 1'b1;
		repeat (12) pulse(4, g);
		chk("div", 8'h00, {5'h00, div});
		chk("valid", 8'h01, {7'h00, valid});
		drain();
		chk("pops", 8'h02, pops);
		chk("last", 8'h01, last);
		$display("test buffer done");
		complete_run();
	end
endmodule // tb_control_pulse_divider_with_skip
`default_nettype wire
